// ---- rtl/hbc_cmp16.v ----
// hbc_cmp16.v: one 16-bit masked comparator with optional direction check
// assumes all inputs are on pclk and already stable for the bus cycle
`default_nettype none

module hbc_cmp16
(
    input  wire [15:0] value,
    input  wire [15:0] ref_val,
    input  wire        use_hi,
    input  wire        use_lo,
    input  wire        rw_check,
    input  wire        rw_want,
    input  wire        rw_now,
    output wire        hit
);

    wire hi_ok;
    wire lo_ok;
    wire rw_ok;

    assign hi_ok = !use_hi || (value[15:8] == ref_val[15:8]);
    assign lo_ok = !use_lo || (value[7:0] == ref_val[7:0]);
    // rw_want 1 matches reads, 0 matches writes
    assign rw_ok = !rw_check || (rw_now == rw_want);
    assign hit   = hi_ok && lo_ok && rw_ok;

endmodule

`default_nettype wire

// ---- rtl/hbc_regs.vh ----
// hbc_regs.vh: register offsets, field positions and reset values of the breakpoint comparator
// assumes inclusion by bare name from rtl files; holds definitions only
`ifndef HBC_REGS_VH
`define HBC_REGS_VH

// byte addresses on the apb side
`define HBC_OFF_CTL0        12'h020
`define HBC_OFF_CTL1        12'h021
`define HBC_OFF_ADDR_HI     12'h022
`define HBC_OFF_ADDR_LO     12'h023
`define HBC_OFF_DATA_HI     12'h024
`define HBC_OFF_DATA_LO     12'h025
`define HBC_OFF_STATUS      12'h026
`define HBC_OFF_ACK         12'h027

// control 0 fields
`define HBC_C0_MODE_HI      7
`define HBC_C0_MODE_LO      6
`define HBC_C0_PROG_ONLY    5
`define HBC_C0_SIZE8        4
`define HBC_C0_RANGE1       3
`define HBC_C0_RANGE0       2
`define HBC_C0_RMASK        8'hec
`define HBC_C0_RESET        8'h00

// control 1 fields
`define HBC_C1_DBE          6
`define HBC_C1_MASK_HI      5
`define HBC_C1_MASK_LO      4
`define HBC_C1_RWE1         3
`define HBC_C1_RW1          2
`define HBC_C1_RWE0         1
`define HBC_C1_RW0          0
`define HBC_C1_RMASK        8'h7f
`define HBC_C1_RESET        8'h00

// mode encodings
`define HBC_MODE_OFF        2'h0
`define HBC_MODE_SWI_DUAL   2'h1
`define HBC_MODE_FULL       2'h2
`define HBC_MODE_BDM_DUAL   2'h3

`endif

// ---- rtl/hbc_req_hold.v ----
// hbc_req_hold.v: sticky request held until the core acknowledges it or flush clears it
// assumes set and ack come from pclk logic; set wins over ack
`default_nettype none

module hbc_req_hold
(
    input  wire pclk,
    input  wire presetn,
    input  wire set,
    input  wire ack,
    input  wire flush,
    output reg  req_q
);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            req_q <= 1'b0;
        else if (set)
            req_q <= 1'b1;
        else if (ack || flush)
            req_q <= 1'b0;
    end

endmodule

`default_nettype wire

// ---- rtl/hbc_top.v ----
// hbc_top.v: hardware breakpoint comparator with apb register access
// assumes core bus signals and debug-unit levels are on pclk; one bus cycle per cpu_valid pulse
// limitation: compare registers are reached one byte per apb word, low byte lane only
`include "hbc_regs.vh"
`default_nettype none

module hbc_top
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        cpu_valid,
    input  wire [15:0] cpu_addr,
    input  wire [15:0] cpu_data,
    input  wire        cpu_read,
    input  wire        cpu_fetch,
    input  wire        cpu_exec,
    input  wire        cpu_boundary,
    input  wire        background_debug_state,
    input  wire        debug_enable,
    output wire        software_interrupt_trap,
    output wire        debug_entry_req,
    output wire        tag_hi,
    output wire        tag_lo
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    reg  [7:0]  ctl0_q;
    reg  [7:0]  ctl1_q;
    reg  [15:0] addr_cmp_q;
    reg  [15:0] data_cmp_q;
    reg         tag_hi_q;
    reg         tag_lo_q;

    wire        wr_en;
    wire        rd_setup;
    wire        mapped;
    wire [7:0]  sel;

    // one decoder feeds write, read and error paths so they cannot disagree
    function [7:0] reg_hit;
        input [11:0] addr;
        begin
            case (addr)
                `HBC_OFF_CTL0:    reg_hit = 8'h01;
                `HBC_OFF_CTL1:    reg_hit = 8'h02;
                `HBC_OFF_ADDR_HI: reg_hit = 8'h04;
                `HBC_OFF_ADDR_LO: reg_hit = 8'h08;
                `HBC_OFF_DATA_HI: reg_hit = 8'h10;
                `HBC_OFF_DATA_LO: reg_hit = 8'h20;
                `HBC_OFF_STATUS:  reg_hit = 8'h40;
                `HBC_OFF_ACK:     reg_hit = 8'h80;
                default:          reg_hit = 8'h00;
            endcase
        end
    endfunction

    // merge one written byte into a 16-bit compare register
    function [15:0] put_byte;
        input [15:0] old;
        input [7:0]  val;
        input        high;
        begin
            if (high)
                put_byte = {val, old[7:0]};
            else
                put_byte = {old[15:8], val};
        end
    endfunction

    // pready tied high: every access ends after one access cycle
    assign pready   = 1'b1;
    assign wr_en    = psel && penable && pwrite;
    // read data is captured in the setup cycle so prdata comes from a flip-flop
    assign rd_setup = psel && !penable && !pwrite;
    assign sel      = reg_hit(paddr);
    assign mapped   = |sel;
    assign pslverr  = psel && penable && !mapped;

    // status, reserved and unmapped offsets ignore writes
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctl0_q <= `HBC_C0_RESET;
        else if (wr_en && sel[0])
            ctl0_q <= pwdata[7:0] & `HBC_C0_RMASK;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctl1_q <= `HBC_C1_RESET;
        else if (wr_en && sel[1])
            ctl1_q <= pwdata[7:0] & `HBC_C1_RMASK;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            addr_cmp_q <= 16'h0000;
        else if (wr_en && (sel[2] || sel[3]))
            addr_cmp_q <= put_byte(addr_cmp_q, pwdata[7:0], sel[2]);
    end

    // data compare bytes also serve as the second address in dual modes
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            data_cmp_q <= 16'h0000;
        else if (wr_en && (sel[4] || sel[5]))
            data_cmp_q <= put_byte(data_cmp_q, pwdata[7:0], sel[4]);
    end

    ////////////////////////////////////////////////////////////////////////
    // mode decode
    wire [1:0] mode;
    wire       mode_swi;
    wire       mode_full;
    wire       mode_bdm2;
    wire       dual;
    wire       prog_only;

    function mode_is;
        input [1:0] cur;
        input [1:0] want;
        begin
            mode_is = (cur == want);
        end
    endfunction

    // size select is not stored: it reads zero and never steers a compare
    assign mode      = {ctl0_q[`HBC_C0_MODE_HI], ctl0_q[`HBC_C0_MODE_LO]};
    assign mode_swi  = mode_is(mode, `HBC_MODE_SWI_DUAL);
    assign mode_full = mode_is(mode, `HBC_MODE_FULL);
    assign mode_bdm2 = mode_is(mode, `HBC_MODE_BDM_DUAL);
    assign dual      = mode_swi || mode_bdm2;
    // swi dual always breaks on program fetches
    assign prog_only = mode_swi || ctl0_q[`HBC_C0_PROG_ONLY];

    ////////////////////////////////////////////////////////////////////////
    // comparators
    wire hit0_addr;
    wire hit1_addr;
    wire hit_data;
    wire rw0_chk;
    wire rw1_chk;
    wire rw0_chk_full;
    wire data_use_hi;
    wire data_use_lo;

    // size select deliberately unused: no effect in dual modes
    assign rw0_chk = !mode_swi && ctl1_q[`HBC_C1_RWE0];
    assign rw1_chk = mode_bdm2 && ctl1_q[`HBC_C1_RWE1];
    // full mode direction check uses breakpoint 0 bits
    assign rw0_chk_full = !ctl1_q[`HBC_C1_RWE0] || (cpu_read == ctl1_q[`HBC_C1_RW0]);
    // full mode data compare only when enabled; a set mask bit drops its byte
    assign data_use_hi = ctl1_q[`HBC_C1_DBE] && !ctl1_q[`HBC_C1_MASK_HI];
    assign data_use_lo = ctl1_q[`HBC_C1_DBE] && !ctl1_q[`HBC_C1_MASK_LO];

    // breakpoint 0: address registers against the address bus
    hbc_cmp16 u_cmp0
    (
        .value    (cpu_addr),
        .ref_val  (addr_cmp_q),
        .use_hi   (1'b1),
        .use_lo   (ctl0_q[`HBC_C0_RANGE0]),
        .rw_check (rw0_chk),
        .rw_want  (ctl1_q[`HBC_C1_RW0]),
        .rw_now   (cpu_read),
        .hit      (hit0_addr)
    );

    // data registers against the address bus for the second breakpoint
    hbc_cmp16 u_cmp1
    (
        .value    (cpu_addr),
        .ref_val  (data_cmp_q),
        .use_hi   (1'b1),
        .use_lo   (ctl0_q[`HBC_C0_RANGE1]),
        .rw_check (rw1_chk),
        .rw_want  (ctl1_q[`HBC_C1_RW1]),
        .rw_now   (cpu_read),
        .hit      (hit1_addr)
    );

    // unused data bytes hold this hit high
    hbc_cmp16 u_cmpd
    (
        .value    (cpu_data),
        .ref_val  (data_cmp_q),
        .use_hi   (data_use_hi),
        .use_lo   (data_use_lo),
        .rw_check (1'b0),
        .rw_want  (1'b0),
        .rw_now   (cpu_read),
        .hit      (hit_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // match qualification
    wire bp0_hit;
    wire bp1_hit;
    wire full_hit;
    wire any_hit;
    wire blocked;
    wire exec_ok;
    wire tag_ok;
    wire fire;
    wire bp1_en;

    // data compare enable doubles as the on switch of the second address breakpoint
    assign bp1_en   = dual && ctl1_q[`HBC_C1_DBE];
    assign bp0_hit  = dual && hit0_addr;
    assign bp1_hit  = bp1_en && hit1_addr;
    assign full_hit = mode_full && hit0_addr && hit_data && rw0_chk_full;
    // a hit only counts on a cycle the core marks valid
    assign any_hit  = cpu_valid && (bp0_hit || bp1_hit || full_hit);
    // blocked ahead of the holders so nothing is latched in debug state
    assign blocked  = background_debug_state;
    // program-only: tagged fetch that really executes
    assign exec_ok  = cpu_fetch && cpu_exec;
    assign tag_ok   = !prog_only || exec_ok;
    assign fire     = any_hit && tag_ok && !blocked;

    // tag marks the byte lane of a program-only hit; held until the next bus cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tag_hi_q <= 1'b0;
        else if (cpu_valid)
            tag_hi_q <= fire && prog_only && !cpu_addr[0];
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tag_lo_q <= 1'b0;
        else if (cpu_valid)
            tag_lo_q <= fire && prog_only && cpu_addr[0];
    end
    assign tag_hi = tag_hi_q;
    assign tag_lo = tag_lo_q;

    ////////////////////////////////////////////////////////////////////////
    // request holding
    wire swi_set;
    wire dbg_set;

    // set wins over ack inside the holder, so a hit on the ack cycle is kept
    assign swi_set = fire && mode_swi;
    assign dbg_set = fire && (mode_full || mode_bdm2) && debug_enable;

    // debug state flushes both requests: the core is already stopped
    hbc_req_hold u_swi
    (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (swi_set),
        .ack     (cpu_boundary),
        .flush   (blocked),
        .req_q   (software_interrupt_trap)
    );

    hbc_req_hold u_dbg
    (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (dbg_set),
        .ack     (cpu_boundary),
        .flush   (blocked),
        .req_q   (debug_entry_req)
    );

    ////////////////////////////////////////////////////////////////////////
    // read mux, registered so data outputs come from flip-flops
    reg [7:0] rd_byte;

    // status: bit 2 debug state, bit 1 debug request, bit 0 software interrupt
    wire [7:0] status_byte;
    assign status_byte = {5'h00, background_debug_state, debug_entry_req, software_interrupt_trap};

    always @*
    begin
        // unmapped and reserved offsets read zero
        rd_byte = 8'h00;
        if (sel[0])
            rd_byte = ctl0_q & `HBC_C0_RMASK;
        if (sel[1])
            rd_byte = ctl1_q & `HBC_C1_RMASK;
        if (sel[2])
            rd_byte = addr_cmp_q[15:8];
        if (sel[3])
            rd_byte = addr_cmp_q[7:0];
        if (sel[4])
            rd_byte = data_cmp_q[15:8];
        if (sel[5])
            rd_byte = data_cmp_q[7:0];
        if (sel[6])
            rd_byte = status_byte;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (rd_setup)
            prdata <= {24'h000000, rd_byte};
    end

endmodule

`default_nettype wire

// ---- verif/hbc_core_model.sv ----
// hbc_core_model.sv: core bus and debug unit stand-in
// assumes its tasks are called from one bench process
`default_nettype none
module hbc_core_model
(
    input  wire logic        pclk,
    output var  logic        cpu_valid,
    output var  logic [15:0] cpu_addr,
    output var  logic [15:0] cpu_data,
    output var  logic        cpu_read,
    output var  logic        cpu_fetch,
    output var  logic        cpu_exec,
    output var  logic        cpu_boundary,
    output var  logic        background_debug_state,
    output var  logic        debug_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        {cpu_valid, cpu_read, cpu_fetch, cpu_exec, cpu_boundary} = 5'h0;
        {background_debug_state, debug_enable} = 2'h0;
        cpu_addr = 16'h0;
        cpu_data = 16'h0;
    end
    // f is {debug state, debug enable, read, fetch, exec}
    task bus(input logic [15:0] a, d, input logic [4:0] f);
        @(posedge pclk);
        {background_debug_state, debug_enable, cpu_read, cpu_fetch, cpu_exec} <= f;
        cpu_addr <= a;
        cpu_data <= d;
        cpu_valid <= 1'b1;
        @(posedge pclk);
        cpu_valid <= 1'b0;
        // idle bus must not echo the last cycle
        cpu_addr <= ~a;
        cpu_data <= ~d;
    endtask
    task ack;
        @(posedge pclk);
        cpu_boundary <= 1'b1;
        @(posedge pclk);
        cpu_boundary <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- verif/hbc_props.sv ----
// hbc_props.sv: port-level assertions for the breakpoint comparator
// assumes binding to hbc_top, every port on pclk
`include "hbc_regs.vh"
`default_nettype none
module hbc_props
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        cpu_valid,
    input wire logic        cpu_fetch,
    input wire logic        cpu_exec,
    input wire logic        cpu_boundary,
    input wire logic        background_debug_state,
    input wire logic        debug_enable,
    input wire logic        software_interrupt_trap,
    input wire logic        debug_entry_req
);
    logic [1:0] mode_q;
    // ports never show the mode, so shadow the apb write
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            mode_q <= 2'h0;
        else if (psel && penable && pwrite && paddr == `HBC_OFF_CTL0)
            mode_q <= pwdata[7:6];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////
    swi_mode_a: assert property ($rose(software_interrupt_trap) |-> $past(mode_q) == `HBC_MODE_SWI_DUAL)
        else $error("swi outside swi dual mode");
    dbg_mode_a: assert property ($rose(debug_entry_req) |-> $past(mode_q[1]))
        else $error("debug request in a non-debug mode");
    bdm_flush_a: assert property (background_debug_state |=> !software_interrupt_trap && !debug_entry_req)
        else $error("request alive in debug state");
    dbg_gate_a: assert property ($rose(debug_entry_req) |-> $past(debug_enable))
        else $error("debug request while debug disabled");
    req_cause_a: assert property (($rose(software_interrupt_trap) || $rose(debug_entry_req))
        |-> $past(cpu_valid) && !$past(background_debug_state)) else $error("request without bus cycle");
    swi_prog_a: assert property ($rose(software_interrupt_trap) |-> $past(cpu_fetch && cpu_exec))
        else $error("swi from a non-executed access");
    swi_hold_a: assert property (software_interrupt_trap && !cpu_boundary && !background_debug_state
        |=> software_interrupt_trap) else $error("swi dropped before ack");
    ack_clear_a: assert property (cpu_boundary && !cpu_valid |=> !software_interrupt_trap && !debug_entry_req)
        else $error("request survived ack");
    ctl0_zero_a: assert property (psel && penable && !pwrite && paddr == `HBC_OFF_CTL0
        |-> prdata[4] == 1'b0 && prdata[1:0] == 2'h0) else $error("control 0 zero bits read one");
    cover property ($rose(software_interrupt_trap));
    cover property ($rose(debug_entry_req));
    cover property (background_debug_state && cpu_valid);
endmodule
bind hbc_top hbc_props u_props(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .cpu_valid, .cpu_fetch, .cpu_exec, .cpu_boundary, .background_debug_state, .debug_enable,
    .software_interrupt_trap, .debug_entry_req);
`default_nettype wire

// ---- verif/test_hw_breakpoint_compare.sv ----
// test_hw_breakpoint_compare.sv: self-checking bench for the breakpoint comparator
// assumes hbc_top, its header and the core model compiled first
`include "hbc_regs.vh"
`default_nettype none
module test_hw_breakpoint_compare;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        cpu_valid, cpu_read, cpu_fetch, cpu_exec, cpu_boundary;
    logic [15:0] cpu_addr, cpu_data, r, a, d;
    logic        background_debug_state, debug_enable, software_interrupt_trap, debug_entry_req, tag_hi, tag_lo;
    logic [7:0]  c0, c1;
    logic [4:0]  f;
    int          n_mismatch, checks_done;
    hbc_top i_dut(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .cpu_valid, .cpu_addr, .cpu_data, .cpu_read, .cpu_fetch, .cpu_exec, .cpu_boundary,
        .background_debug_state, .debug_enable, .software_interrupt_trap, .debug_entry_req, .tag_hi, .tag_lo);
    hbc_core_model u_core(.pclk, .cpu_valid, .cpu_addr, .cpu_data, .cpu_read, .cpu_fetch, .cpu_exec,
        .cpu_boundary, .background_debug_state, .debug_enable);
    ////////////////////////////////////////////
    function logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // compare values fixed at 1234 and 5678; result is {swi, debug}
    function logic [1:0] ex(input logic [7:0] k0, k1, input logic [15:0] ca, cd, input logic [4:0] cf);
        logic b0, b1, q0, q1, pg, dm;
        b0 = ca[15:8] == 8'h12 && (!k0[2] || ca[7:0] == 8'h34);
        b1 = k1[6] && ca[15:8] == 8'h56 && (!k0[3] || ca[7:0] == 8'h78);
        q0 = !k1[1] || k1[0] == cf[2];
        q1 = !k1[3] || k1[2] == cf[2];
        pg = !k0[5] || cf[1] && cf[0];
        dm = !k1[6] || (k1[5] || cd[15:8] == 8'h56) && (k1[4] || cd[7:0] == 8'h78);
        if (cf[4])
            return 2'h0;
        case (k0[7:6])
            2'h1: return {(b0 || b1) && cf[1] && cf[0], 1'b0};
            2'h2: return {1'b0, b0 && q0 && dm && pg && cf[3]};
            2'h3: return {1'b0, (b0 && q0 || b1 && q1) && pg && cf[3]};
            default: return 2'h0;
        endcase
    endfunction
    // tags follow every program-only hit, whether or not debug is enabled; result is {hi, lo}
    function logic [1:0] et(input logic [7:0] k0, k1, input logic [15:0] ca, cd, input logic [4:0] cf);
        logic h;
        h = |ex(k0, k1, ca, cd, cf | 5'h08) && (k0[7:6] == 2'h1 || k0[5]);
        return {h && !ca[0], h && ca[0]};
    endfunction
    task chk(input string n, input logic [7:0] e, g);
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task apb(input logic w, input logic [11:0] ad, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wrap_up;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial
    begin
        repeat (30000) @(posedge pclk);
        n_mismatch++;
        wrap_up;
    end
    initial
    begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        n_mismatch = 0;
        checks_done = 0;
        r = 16'h005b;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `HBC_OFF_CTL0, 8'h00);
        chk("ctl0 reset", `HBC_C0_RESET, rd[7:0]);
        apb(1'b1, `HBC_OFF_CTL0, 8'hff);
        apb(1'b0, `HBC_OFF_CTL0, 8'h00);
        chk("ctl0 bits", `HBC_C0_RMASK, rd[7:0]);
        apb(1'b0, 12'h040, 8'h00);
        chk("unmapped", 8'h01, {7'h0, er});
        chk("unmapped data", 8'h00, rd[7:0]);
        for (int i = 0; i < 4; i++)
            apb(1'b1, 12'(`HBC_OFF_ADDR_HI + i), 8'(32'h12345678 >> (24 - 8 * i)));
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, 12'(`HBC_OFF_ADDR_HI + i), 8'h00);
            chk("compare reg", 8'(32'h12345678 >> (24 - 8 * i)), rd[7:0]);
        end
        repeat (300)
        begin
            r = nx(r);
            c0 = {r[7:2], 2'h0};
            r = nx(r);
            c1 = {1'b0, r[6:0]};
            apb(1'b1, `HBC_OFF_CTL0, c0);
            apb(1'b1, `HBC_OFF_CTL1, c1);
            r = nx(r);
            a = {r[0] ? 8'h12 : 8'h56, r[1] ? 8'h34 : (r[13] ? 8'h78 : 8'h79)};
            d = {r[2] ? 8'h56 : 8'h9a, r[3] ? 8'h78 : 8'hbc};
            f = {r[6:4] == 3'h0, r[7], r[8], r[9] | r[10], r[11] | r[12]};
            u_core.bus(a, d, f);
            repeat (3) @(posedge pclk);
            #1;
            chk("req", {6'h0, ex(c0, c1, a, d, f)}, {6'h0, software_interrupt_trap, debug_entry_req});
            chk("tag", {6'h0, et(c0, c1, a, d, f)}, {6'h0, tag_hi, tag_lo});
            u_core.ack();
            #1;
            chk("cleared", 8'h00, {6'h0, software_interrupt_trap, debug_entry_req});
        end
        wrap_up;
    end
endmodule
`default_nettype wire
